//--- buck_ctrl_defines.svh
// constants for the buck setpoint and power-ok interrupt block
`ifndef BUCK_CTRL_DEFINES_SVH
`define BUCK_CTRL_DEFINES_SVH
`define NUM_RAILS 4
`define CODE_W 8
`define MV_W 13
`define BASE_MV 13'd600
`define COARSE_STEP_MV 13'd20
`define FINE_STEP_MV 13'd5
`define COARSE_MAX_MV 13'd5260
`define POK_THRESH_PCT 10
`define STEP_TIME_NS 1000
`define CLK_PERIOD_NS 25
`define STEP_CYCLES ((`STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_CNT_W 6
`endif

//--- buck_ctrl_pkg.sv
// types for the buck setpoint and power-ok interrupt block
package buck_ctrl_pkg;
	typedef logic [7:0]  code_t;
	typedef logic [12:0] mv_t;
endpackage

//--- setpoint_slew.sv
// one rail: setpoint stepping and voltage decode
`timescale 1ns/1ps
`default_nettype none
`include "buck_ctrl_defines.svh"
module setpoint_slew (
	input  wire logic                   clk_i,
	input  wire logic                   sys_rst_i,
	input  wire logic [7:0]             target_code_i,
	input  wire logic                   fine_mode_i,
	output logic      [7:0]             applied_code_o,
	output logic      [12:0]            target_mv_o,
	output logic                        stepping_o
);
	logic [`STEP_CNT_W-1:0] tick_cnt;
	wire                    tick_done = (tick_cnt == `STEP_CNT_W'(`STEP_CYCLES - 1));
	wire                    differ    = (applied_code_o != target_code_i);
	wire                    go_up     = (applied_code_o < target_code_i);
	wire [7:0]              next_code = go_up ? applied_code_o + 8'h01 : applied_code_o - 8'h01;
	wire [12:0]             coarse_mv = `BASE_MV + 13'(applied_code_o) * `COARSE_STEP_MV;
	wire [12:0]             fine_mv   = `BASE_MV + 13'(applied_code_o) * `FINE_STEP_MV;
	wire [12:0]             sat_mv    = (coarse_mv > `COARSE_MAX_MV) ? `COARSE_MAX_MV : coarse_mv;
	// (R7) one code per step
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			applied_code_o <= 8'h00;
			tick_cnt       <= '0;
		end else if (differ) begin
			tick_cnt <= tick_done ? '0 : tick_cnt + 1'b1;
			if (tick_done)
				applied_code_o <= next_code;
		end else begin
			tick_cnt <= '0;
		end
	end
	// (R5) (R6) (R10) per-rail decode
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			target_mv_o <= `BASE_MV;
			stepping_o  <= 1'b0;
		end else begin
			target_mv_o <= fine_mode_i ? fine_mv : sat_mv;
			stepping_o  <= differ;
		end
	end
	// (R7) single step moves
	a_step_size: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R7)
		applied_code_o != $past(applied_code_o) |->
		(applied_code_o - $past(applied_code_o) == 8'h01) ||
		($past(applied_code_o) - applied_code_o == 8'h01))
		else $error("setpoint jumped more than one code");
	// (R5) coarse saturation
	a_coarse_sat: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R5)
		!fine_mode_i && $past(!fine_mode_i) |-> target_mv_o <= `COARSE_MAX_MV)
		else $error("coarse voltage above ceiling");
	// (R6) fine ceiling
	a_fine_top: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R6)
		$past(fine_mode_i) && $past(applied_code_o) == 8'hFF |-> target_mv_o == 13'd1875)
		else $error("fine top code wrong");
	c_slewing: cover property (@(posedge clk_i) disable iff (sys_rst_i) stepping_o ##1 !stepping_o);
endmodule
`default_nettype wire

//--- buck_setpoint_pok.sv
// four-rail setpoint control with power-ok status and latched interrupt
`timescale 1ns/1ps
`default_nettype none
`include "buck_ctrl_defines.svh"
// Operation
// (R1) power-ok bit is 0 while that output sits below its threshold
// (R2) undervoltage raises the interrupt only when that rail's fault enable is 1
// (R3) interrupt holds until rail off or regulating, and its status read
// (R4) interrupt latched: recovery alone or read alone never releases it
// (R5) coarse mode 0.6V plus 20mV per code, saturating at 5.26V
// (R6) fine mode 0.6V plus 5mV per code, 1.875V at all ones
// (R7) setpoint changes walk one code at a time to the target
// (R8) undervoltage fault ignored while the setpoint is walking
// (R9) each rail follows its host-written enable bit
// (R10) per-rail bit selects coarse or fine decoding
module buck_setpoint_pok (
	input  wire logic                   clk_i,
	input  wire logic                   sys_rst_i,
	input  wire logic [3:0]             rail_enable_i,
	input  wire logic [3:0]             fault_irq_enable_i,
	input  wire logic [3:0]             fine_mode_i,
	input  wire logic [3:0]             voltage_scaling_enable_i,
	input  wire logic [31:0]            setpoint_primary_i,
	input  wire logic [31:0]            setpoint_secondary_i,
	input  wire logic [3:0]             below_threshold_i,
	input  wire logic [3:0]             status_read_i,
	output logic      [3:0]             rail_on_o,
	output logic      [3:0]             output_in_regulation_o,
	output logic      [31:0]            output_setpoint_code_o,
	output logic      [51:0]            target_mv_o,
	output logic      [3:0]             stepping_o,
	output logic                        interrupt_request_n_o
);
	logic [3:0]  uv_s1, uv_s2, uv_s3;
	logic [3:0]  pending;
	logic [3:0]  read_seen;
	logic [3:0]  uv_now;
	logic [3:0]  next_pending;
	logic [3:0]  next_read_seen;
	logic [31:0] applied;
	logic [51:0] mv_all;
	logic [3:0]  step_all;
	logic [3:0]  uv_filt;
	wire  [3:0]  uv_agree_set = uv_s2 & uv_s3;
	wire  [3:0]  uv_agree_clr = ~uv_s2 & ~uv_s3;
	// analog comparator crosses clock domain
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			uv_s1 <= 4'h0;
			uv_s2 <= 4'h0;
			uv_s3 <= 4'h0;
		end else begin
			uv_s1 <= below_threshold_i;
			uv_s2 <= uv_s1;
			uv_s3 <= uv_s2;
		end
	end
	// (R1) comparator change taken once stages two and three agree
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			uv_filt <= 4'h0;
		end else begin
			uv_filt <= uv_agree_set | (uv_filt & ~uv_agree_clr);
		end
	end
	genvar g;
	generate
		for (g = 0; g < `NUM_RAILS; g++) begin : g_rail
			wire buck_ctrl_pkg::code_t sel_code = voltage_scaling_enable_i[g] ?
				setpoint_secondary_i[g*8 +: 8] : setpoint_primary_i[g*8 +: 8];
			// (R1) (R8) filtered fault, masked while walking or off
			assign uv_now[g] = uv_filt[g] & rail_on_o[g] & ~step_all[g];
			wire recovered = ~rail_on_o[g] | ~uv_now[g];
			// (R2) enabled undervoltage sets latch
			wire set_irq = uv_now[g] & fault_irq_enable_i[g];
			// (R3) (R4) clear only after read and recovery
			wire clr_irq = (read_seen[g] | status_read_i[g]) & recovered;
			assign next_pending[g] = set_irq | (pending[g] & ~clr_irq);
			// (R3) read kept unless a fresh fault restarts the latch
			wire fresh_fault = set_irq & ~pending[g];
			assign next_read_seen[g] = next_pending[g] & ~fresh_fault &
				(read_seen[g] | status_read_i[g]);
			// (R2) per-rail set
			a_rail_set: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R2)
				uv_now[g] && fault_irq_enable_i[g] |=> pending[g])
				else $error("enabled rail fault not latched");
			// (R2) disabled rail never latches
			a_rail_masked: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R2)
				!fault_irq_enable_i[g] && !pending[g] |=> !pending[g])
				else $error("disabled rail fault latched");
			// (R4) latch holds while fault stands
			a_rail_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R4)
				pending[g] && !recovered |=> pending[g])
				else $error("rail latch dropped during fault");
			// (R4) latch holds without read
			a_rail_noread: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R4)
				pending[g] && !read_seen[g] && !status_read_i[g] |=> pending[g])
				else $error("rail latch dropped without read");
			// (R3) read plus recovery clears
			a_rail_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R3)
				pending[g] && recovered && (read_seen[g] || status_read_i[g]) |=> !pending[g])
				else $error("rail latch not cleared");
			// (R1) status low under threshold
			a_rail_pok: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R1)
				uv_filt[g] |=> !output_in_regulation_o[g])
				else $error("rail power-ok high in undervoltage");
			// (R9) switched-off rail flags nothing
			a_off_mask: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R9)
				!rail_on_o[g] |-> !uv_now[g])
				else $error("fault flagged on a rail that is off");
			setpoint_slew u_slew (
				.clk_i          (clk_i),
				.sys_rst_i      (sys_rst_i),
				.target_code_i  (sel_code),
				.fine_mode_i    (fine_mode_i[g]),
				.applied_code_o (applied[g*8 +: 8]),
				.target_mv_o    (mv_all[g*13 +: 13]),
				.stepping_o     (step_all[g])
			);
		end
	endgenerate
	// (R9) enable follows host bit
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rail_on_o <= 4'h0;
		end else begin
			rail_on_o <= rail_enable_i;
		end
	end
	// (R1) power-ok status
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			output_in_regulation_o <= 4'h0;
		end else begin
			output_in_regulation_o <= rail_on_o & ~uv_filt;
		end
	end
	// (R7) applied codes out
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			output_setpoint_code_o <= 32'h0000_0000;
		end else begin
			output_setpoint_code_o <= applied;
		end
	end
	// (R5) (R6) decoded millivolts out
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			target_mv_o <= 52'h0_0000_0000_0000;
		end else begin
			target_mv_o <= mv_all;
		end
	end
	// (R8) walking flags out
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stepping_o <= 4'h0;
		end else begin
			stepping_o <= step_all;
		end
	end
	// (R3) (R4) latched interrupt state
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pending <= 4'h0;
		end else begin
			pending <= next_pending;
		end
	end
	// (R3) remembered status reads
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			read_seen <= 4'h0;
		end else begin
			read_seen <= next_read_seen;
		end
	end
	// (R2) interrupt pin
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			interrupt_request_n_o <= 1'b1;
		end else begin
			interrupt_request_n_o <= ~|next_pending;
		end
	end
	// (R2) enabled fault raises interrupt
	a_irq_raise: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R2)
		|(uv_now & fault_irq_enable_i) |=> !interrupt_request_n_o)
		else $error("enabled fault did not raise interrupt");
	// (R4) no release without read
	a_irq_needs_read: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R4)
		!interrupt_request_n_o && status_read_i == 4'h0 && read_seen == 4'h0
		|=> !interrupt_request_n_o)
		else $error("interrupt released without a status read");
	// (R3) no release while fault stands
	a_irq_holds_fault: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R3)
		|(pending & uv_now) |=> !interrupt_request_n_o)
		else $error("interrupt released while fault present");
	// (R1) status low under threshold
	a_pok_low: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R1)
		|uv_filt |=> (output_in_regulation_o & $past(uv_filt)) == 4'h0)
		else $error("power-ok high during undervoltage");
	// (R8) walking masks faults
	a_walk_mask: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R8)
		|step_all |-> (uv_now & step_all) == 4'h0)
		else $error("fault flagged while stepping");
	// (R9) enable tracking
	a_enable_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R9)
		1'b1 |=> rail_on_o == $past(rail_enable_i))
		else $error("rail enable not followed");
	c_irq_cycle: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		interrupt_request_n_o ##1 !interrupt_request_n_o ##[1:50] interrupt_request_n_o);
	c_read_first: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		|(pending & status_read_i & uv_now));
	c_masked: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		|(uv_now & ~fault_irq_enable_i));
endmodule
`default_nettype wire

//--- host_model.sv
// host side model: power-ok status reads
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic       clk_i,
	output logic      [3:0] status_read_o
);
	initial begin
		status_read_o = 4'h0;
	end
	task automatic read_status(input int g);
		@(negedge clk_i);
		status_read_o[g] = 1'b1;
		@(negedge clk_i);
		status_read_o[g] = 1'b0;
	endtask
endmodule
`default_nettype wire

//--- testbench.sv
// testbench for the four-rail setpoint and power-ok block
`timescale 1ns/1ps
`default_nettype none
`include "buck_ctrl_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
	logic        clk_i = 0, sys_rst_i = 1, irq_n;
	logic [3:0]  en = 0, fim = 0, fine = 0, dvs = 0, below = 0, rd, on, pok, stp;
	logic [31:0] sp0 = 0, sp1 = 0, code, prev;
	logic [51:0] mv;
	int          errors = 0, comparisons = 0;
	always #12.5 clk_i = ~clk_i;
	host_model i_host_model (.clk_i(clk_i), .status_read_o(rd));
	buck_setpoint_pok i_buck_setpoint_pok (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.rail_enable_i(en), .fault_irq_enable_i(fim), .fine_mode_i(fine),
		.voltage_scaling_enable_i(dvs), .setpoint_primary_i(sp0),
		.setpoint_secondary_i(sp1), .below_threshold_i(below), .status_read_i(rd),
		.rail_on_o(on), .output_in_regulation_o(pok), .output_setpoint_code_o(code),
		.target_mv_o(mv), .stepping_o(stp), .interrupt_request_n_o(irq_n));
	function automatic logic [12:0] exp_mv(logic [7:0] c, logic f);
		logic [12:0] v;
		v = f ? `BASE_MV + `FINE_STEP_MV * c : `BASE_MV + `COARSE_STEP_MV * c;
		return (!f && v > `COARSE_MAX_MV) ? `COARSE_MAX_MV : v;
	endfunction
	task automatic report_and_stop();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic wait_n(int n);
		repeat (n) @(negedge clk_i);
	endtask
	// walk to target, watching each change of applied code
	task automatic settle();
		int n;
		prev = code;
		wait_n(3);
		for (n = 0; n < 12000 && stp !== 4'h0; n++) begin
			@(negedge clk_i);
			for (int g = 0; g < 4; g++)
				if (code[8*g+:8] !== prev[8*g+:8])
					`CHK(code[8*g+:8] - prev[8*g+:8] inside {8'h01, 8'hFF}, 1'b1)
			prev = code;
		end
		if (n == 12000) begin
			errors++;
			report_and_stop();
		end
		wait_n(3);
	endtask
	task automatic check_mv(logic [31:0] c);
		for (int g = 0; g < 4; g++) begin
			`CHK(code[8*g+:8], c[8*g+:8])
			`CHK(mv[13*g+:13], exp_mv(c[8*g+:8], fine[g]))
		end
	endtask
	task automatic fault(logic [3:0] b, logic [3:0] p, logic q);
		below = b;
		wait_n(6);
		`CHK(pok, p)
		`CHK(irq_n, q)
	endtask
	initial begin
		wait_n(2);
		sys_rst_i = 0;
		`CHK(irq_n, 1'b1)
		en = 4'hF;
		sp0 = 32'hFFFF_E9E8;
		fine = 4'h8;
		settle();
		`CHK(on, 4'hF)
		check_mv(sp0);
		dvs = 4'hF;
		sp1 = 32'hFE80_0100;
		fine = 4'hF;
		settle();
		check_mv(sp1);
		fim = 4'h1;
		fault(4'h3, 4'hC, 1'b0);
		i_host_model.read_status(0);
		fault(4'h3, 4'hC, 1'b0);
		fault(4'h2, 4'hD, 1'b1);
		fault(4'h3, 4'hC, 1'b0);
		fault(4'h2, 4'hD, 1'b0);
		i_host_model.read_status(0);
		fault(4'h2, 4'hD, 1'b1);
		fault(4'h3, 4'hC, 1'b0);
		en = 4'hE;
		fault(4'h3, 4'hC, 1'b0);
		`CHK(on, 4'hE)
		i_host_model.read_status(0);
		fault(4'h3, 4'hC, 1'b1);
		en = 4'hF;
		fim = 4'h4;
		below = 4'h0;
		wait_n(6);
		sp1[23:16] = 8'h81;
		wait_n(4);
		below = 4'h4;
		wait_n(10);
		`CHK(stp, 4'h4)
		`CHK(irq_n, 1'b1)
		below = 4'h0;
		settle();
		check_mv(sp1);
		`CHK(irq_n, 1'b1)
		report_and_stop();
	end
endmodule
`default_nettype wire
